// [dv/uart_modem_control_loopback_bench.sv]
// Self-checking bench for the modem line control block
`timescale 1ns/100ps
`default_nettype none
module uart_modem_control_loopback_bench;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic tx_serial = 1'b1;
  logic tx_ir_n = 1'b1;
  logic rx_above_trig = 1'b0;
  logic [umlc_pkg::LSR_W-1:0] line_status = 16'h0000;
  logic [2:0] mdm_assert = 3'b111;
  logic mdm_data = 1'b1;
  int err_count = 0;
  int checks_done = 0;
  logic [31:0] mlc_v [3] = '{32'h0000_000E, 32'h0000_000A, 32'h0000_0006};
  logic [10:0] pin_v [3] = '{11'h0F0, 11'h2F0, 11'h1F0};
  wire logic hreadyout, hresp, rx_serial, rx_ir, cts_eff_n, dsr_eff_n, ri_eff_n, dcd_eff_n;
  wire logic ser_out_pin, ir_out_n_pin, ser_in_pin, ir_in_pin, cts_n, dsr_n, ring_n, dcd_n;
  wire logic rts_n, user_line_a_n, user_line_b_n;
  wire logic [31:0] hrdata;
  wire logic [10:0] pins = {rts_n, user_line_a_n, user_line_b_n, ser_out_pin, ir_out_n_pin,
    rx_serial, rx_ir, cts_eff_n, dsr_eff_n, ri_eff_n, dcd_eff_n};

  always #2 ref_clk = ~ref_clk;

  umlc_top i_umlc_top (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tx_serial(tx_serial),
    .tx_ir_n(tx_ir_n), .rx_above_trig(rx_above_trig), .line_status(line_status),
    .rx_serial(rx_serial), .rx_ir(rx_ir), .cts_eff_n(cts_eff_n), .dsr_eff_n(dsr_eff_n),
    .ri_eff_n(ri_eff_n), .dcd_eff_n(dcd_eff_n), .ser_out_pin(ser_out_pin),
    .ir_out_n_pin(ir_out_n_pin), .ser_in_pin(ser_in_pin), .ir_in_pin(ir_in_pin),
    .cts_n(cts_n), .dsr_n(dsr_n), .ring_indicator_n(ring_n), .dcd_n(dcd_n), .rts_n(rts_n),
    .user_line_a_n(user_line_a_n), .user_line_b_n(user_line_b_n));

  umlc_modem i_umlc_modem (.rts_n(rts_n), .assert_lines(mdm_assert), .data(mdm_data),
    .cts_n(cts_n), .dsr_n(dsr_n), .ring_indicator_n(ring_n), .dcd_n(dcd_n),
    .ser_in_pin(ser_in_pin), .ir_in_pin(ir_in_pin));

  task automatic complete_run;
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Lets pins settle through register and synchroniser stages, then compares
  task automatic cmp_pins(input string name, input logic [10:0] exp, input logic [10:0] mask);
    repeat (6) @(posedge ref_clk);
    #1;
    checks_done++;
    if (((pins ^ exp) & mask) !== 11'h000) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, pins);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    bus(1'b1, a, wd, rd);
  endtask

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0000_0000, rd);
    cmp_word(name, exp, rd);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd_chk("mlc reset", umlc_pkg::MLC_ADDR, umlc_pkg::MLC_RST);
    cmp_pins("idle lines", 11'h7F8, 11'h7FF);
    foreach (mlc_v[i]) begin
      wr(umlc_pkg::MLC_ADDR, mlc_v[i]);
      cmp_pins("user and rts lines", pin_v[i], 11'h7FF);
    end
    rd_chk("mlc readback", umlc_pkg::MLC_ADDR, 32'h0000_0006);
    wr(umlc_pkg::CTRL_ADDR, 32'h0000_0001);
    rx_above_trig <= 1'b1;
    wr(umlc_pkg::MLC_ADDR, 32'h0000_0022);
    cmp_pins("rts held off", 11'h7F8, 11'h7FF);
    wr(umlc_pkg::CTRL_ADDR, 32'h0000_0000);
    cmp_pins("rts fifo off", 11'h3F0, 11'h7FF);
    wr(umlc_pkg::CTRL_ADDR, 32'h0000_0001);
    rx_above_trig <= 1'b0;
    cmp_pins("rts below level", 11'h3F0, 11'h7FF);
    wr(umlc_pkg::MLC_ADDR, 32'h0000_0002);
    rx_above_trig <= 1'b1;
    cmp_pins("rts no flow", 11'h3F0, 11'h7FF);
    mdm_assert <= 3'b010;
    cmp_pins("modem inputs", 11'h3F5, 11'h7FF);
    wr(umlc_pkg::MLC_ADDR, 32'h0000_0010);
    tx_serial <= 1'b0;
    cmp_pins("loop idle", 11'h7CF, 11'h7EF);
    wr(umlc_pkg::MLC_ADDR, 32'h0000_001E);
    tx_serial <= 1'b1;
    mdm_data <= 1'b0;
    cmp_pins("loop map", 11'h7E4, 11'h7EF);
    rd_chk("modem status", umlc_pkg::MSTAT_ADDR, 32'h0000_000D);
    wr(umlc_pkg::MLC_ADDR, 32'hFFFF_FFFF);
    tx_ir_n <= 1'b0;
    rd_chk("mlc reserved", umlc_pkg::MLC_ADDR, 32'h0000_007E);
    cmp_pins("ir loop low", 11'h714, 11'h75F);
    wr(umlc_pkg::MLC_ADDR, 32'hFFFF_FFFF);
    tx_ir_n <= 1'b1;
    cmp_pins("ir loop high", 11'h704, 11'h75F);
    wr(umlc_pkg::LSR_ADDR, 32'h0000_FFFF);
    line_status <= 16'hA5C3;
    rd_chk("line status", umlc_pkg::LSR_ADDR, 32'h0000_A5C3);
    wr(32'h5000_1120, 32'hFFFF_FFFF);
    rd_chk("unmapped", 32'h5000_1120, 32'h0000_0000);
    rd_chk("mlc kept", umlc_pkg::MLC_ADDR, 32'h0000_007E);
    cmp_word("response", 32'h0000_0002, {30'h0000_0000, hreadyout, hresp});
    complete_run;
  end

  initial begin
    repeat (4000) @(posedge ref_clk);
    err_count++;
    complete_run;
  end
endmodule // uart_modem_control_loopback_bench
`default_nettype wire

// [dv/umlc_modem.sv]
// Behavioural modem on the far side of the serial and modem lines
`timescale 1ns/100ps
`default_nettype none
module umlc_modem (
  // Line from the block
  input wire logic rts_n,
  // Bench control
  input wire logic [2:0] assert_lines,
  input wire logic data,
  // Lines to the block
  output logic cts_n,
  output logic dsr_n,
  output logic ring_indicator_n,
  output logic dcd_n,
  output logic ser_in_pin,
  output logic ir_in_pin
);
  // Clear to send only while the block says it is ready
  assign cts_n = rts_n;
  assign dsr_n = !assert_lines[2];
  assign ring_indicator_n = !assert_lines[1];
  assign dcd_n = !assert_lines[0];
  assign ser_in_pin = data;
  assign ir_in_pin = data;
endmodule // umlc_modem
`default_nettype wire

// [inc/umlc_pkg.sv]
// Package with the register map, field positions and reset values of the modem line control block
package umlc_pkg;

  // Register byte addresses
  localparam logic [31:0] MLC_ADDR = 32'h5000_1110;
  localparam logic [31:0] LSR_ADDR = 32'h5000_1114;
  localparam logic [31:0] CTRL_ADDR = 32'h5000_1118;
  localparam logic [31:0] MSTAT_ADDR = 32'h5000_111C;

  // Fields of modem_line_control
  localparam int RTS_BIT = 1;
  localparam int OUT1_BIT = 2;
  localparam int OUT2_BIT = 3;
  localparam int LB_BIT = 4;
  localparam int AFCE_BIT = 5;
  localparam int SIRE_BIT = 6;
  localparam logic [31:0] MLC_RST = 32'h0000_0000;

  // Fields of the line control register
  localparam int FIFO_EN_BIT = 0;

  // Fields of the modem status register, each reads 1 when asserted
  localparam int ST_CTS = 0;
  localparam int ST_DSR = 1;
  localparam int ST_RI = 2;
  localparam int ST_DCD = 3;
  localparam int ST_RTS = 4;
  localparam int ST_OUT1 = 5;
  localparam int ST_OUT2 = 6;

  // Width of the line status word passed through
  localparam int LSR_W = 16;

  // Bus encodings
  localparam int HTRANS_ACT_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // Synchronised pin count and positions
  localparam int NSYNC = 6;
  localparam int SY_CTS = 0;
  localparam int SY_DSR = 1;
  localparam int SY_RI = 2;
  localparam int SY_DCD = 3;
  localparam int SY_SER = 4;
  localparam int SY_IR = 5;

endpackage

// [verilog/umlc_sync2.sv]
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module umlc_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // umlc_sync2
`default_nettype wire

// [verilog/umlc_top.sv]
// Modem line control register, request-to-send gating and diagnostic loopback
`timescale 1ns/100ps
`default_nettype none
module umlc_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // From the rest of the serial port
  input wire logic tx_serial,
  input wire logic tx_ir_n,
  input wire logic rx_above_trig,
  input wire logic [umlc_pkg::LSR_W-1:0] line_status,
  // To the rest of the serial port
  output logic rx_serial,
  output logic rx_ir,
  output logic cts_eff_n,
  output logic dsr_eff_n,
  output logic ri_eff_n,
  output logic dcd_eff_n,
  // Serial pins
  output logic ser_out_pin,
  output logic ir_out_n_pin,
  input wire logic ser_in_pin,
  input wire logic ir_in_pin,
  // Modem pins
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ring_indicator_n,
  input wire logic dcd_n,
  output logic rts_n,
  output logic user_line_a_n,
  output logic user_line_b_n
);

  typedef struct packed {
    logic rts_b;
    logic out1_b;
    logic out2_b;
    logic lb_b;
    logic afce_b;
    logic sire_b;
    logic fifo_en_b;
    logic wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] rdata;
    logic ser_out;
    logic ir_out_n;
    logic rx_ser;
    logic rx_ir;
    logic cts_n;
    logic dsr_n;
    logic ring_n;
    logic dcd_n;
    logic rts_n;
    logic ua_n;
    logic ub_n;
  } umlc_state_t;

  localparam umlc_state_t RST_S = '{
    rts_b: umlc_pkg::MLC_RST[umlc_pkg::RTS_BIT],
    out1_b: umlc_pkg::MLC_RST[umlc_pkg::OUT1_BIT],
    out2_b: umlc_pkg::MLC_RST[umlc_pkg::OUT2_BIT],
    lb_b: umlc_pkg::MLC_RST[umlc_pkg::LB_BIT],
    afce_b: umlc_pkg::MLC_RST[umlc_pkg::AFCE_BIT],
    sire_b: umlc_pkg::MLC_RST[umlc_pkg::SIRE_BIT],
    fifo_en_b: 1'b0,
    wr_pend: 1'b0,
    wr_addr: umlc_pkg::RD_ZERO,
    rdata: umlc_pkg::RD_ZERO,
    ser_out: 1'b1,
    ir_out_n: 1'b1,
    rx_ser: 1'b1,
    rx_ir: 1'b0,
    cts_n: 1'b1,
    dsr_n: 1'b1,
    ring_n: 1'b1,
    dcd_n: 1'b1,
    rts_n: 1'b1,
    ua_n: 1'b1,
    ub_n: 1'b1
  };

  umlc_state_t s_q;
  umlc_state_t s_d;
  logic [umlc_pkg::NSYNC-1:0] pin_raw;
  logic [umlc_pkg::NSYNC-1:0] pin_sy;
  logic take;
  logic lb_plain;
  logic lb_ir;
  logic rts_req;
  logic [31:0] rd_word;

  // Pin inputs pass two flip-flops
  assign pin_raw = {ir_in_pin, ser_in_pin, dcd_n, ring_indicator_n, dsr_n, cts_n};

  umlc_sync2 #(
    .W(umlc_pkg::NSYNC),
    .RST_VAL(6'b01_1111)
  ) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .d(pin_raw),
    .q(pin_sy)
  );

  assign take = hsel && hready && htrans[umlc_pkg::HTRANS_ACT_BIT];
  assign lb_plain = s_q.lb_b && !s_q.sire_b;
  assign lb_ir = s_q.lb_b && s_q.sire_b;

  // Flow control gate applies only with FIFOs on
  assign rts_req = s_q.rts_b &&
    !(s_q.afce_b && s_q.fifo_en_b && rx_above_trig);

  always_comb begin
    s_d = s_q;
    rd_word = umlc_pkg::RD_ZERO;
    // Data phase of a write updates the registers
    s_d.wr_pend = take && hwrite;
    if (take) begin
      s_d.wr_addr = haddr;
    end
    if (s_q.wr_pend && (s_q.wr_addr == umlc_pkg::MLC_ADDR)) begin
      // Reserved bits are not stored
      s_d.rts_b = hwdata[umlc_pkg::RTS_BIT];
      s_d.out1_b = hwdata[umlc_pkg::OUT1_BIT];
      s_d.out2_b = hwdata[umlc_pkg::OUT2_BIT];
      s_d.lb_b = hwdata[umlc_pkg::LB_BIT];
      s_d.afce_b = hwdata[umlc_pkg::AFCE_BIT];
      s_d.sire_b = hwdata[umlc_pkg::SIRE_BIT];
    end
    if (s_q.wr_pend && (s_q.wr_addr == umlc_pkg::CTRL_ADDR)) begin
      s_d.fifo_en_b = hwdata[umlc_pkg::FIFO_EN_BIT];
    end
    // Read data taken in the address phase, after any write now ending
    unique case (haddr)
      umlc_pkg::MLC_ADDR: begin
        rd_word[umlc_pkg::RTS_BIT] = s_d.rts_b;
        rd_word[umlc_pkg::OUT1_BIT] = s_d.out1_b;
        rd_word[umlc_pkg::OUT2_BIT] = s_d.out2_b;
        rd_word[umlc_pkg::LB_BIT] = s_d.lb_b;
        rd_word[umlc_pkg::AFCE_BIT] = s_d.afce_b;
        rd_word[umlc_pkg::SIRE_BIT] = s_d.sire_b;
      end
      umlc_pkg::LSR_ADDR: begin
        rd_word[umlc_pkg::LSR_W-1:0] = line_status;
      end
      umlc_pkg::CTRL_ADDR: begin
        rd_word[umlc_pkg::FIFO_EN_BIT] = s_d.fifo_en_b;
      end
      umlc_pkg::MSTAT_ADDR: begin
        rd_word[umlc_pkg::ST_CTS] = !s_q.cts_n;
        rd_word[umlc_pkg::ST_DSR] = !s_q.dsr_n;
        rd_word[umlc_pkg::ST_RI] = !s_q.ring_n;
        rd_word[umlc_pkg::ST_DCD] = !s_q.dcd_n;
        rd_word[umlc_pkg::ST_RTS] = !s_q.rts_n;
        rd_word[umlc_pkg::ST_OUT1] = !s_q.ua_n;
        rd_word[umlc_pkg::ST_OUT2] = !s_q.ub_n;
      end
      default: begin
        rd_word = umlc_pkg::RD_ZERO;
      end
    endcase
    if (take && !hwrite) begin
      s_d.rdata = rd_word;
    end
    // Modem output lines
    s_d.rts_n = s_q.lb_b ? 1'b1 : !rts_req;
    s_d.ua_n = s_q.lb_b ? 1'b1 : !s_q.out1_b;
    s_d.ub_n = s_q.lb_b ? 1'b1 : !s_q.out2_b;
    // Serial lines, looped in diagnostic mode
    s_d.ser_out = lb_plain ? 1'b1 : tx_serial;
    s_d.rx_ser = lb_plain ? tx_serial : pin_sy[umlc_pkg::SY_SER];
    s_d.ir_out_n = lb_ir ? 1'b0 : tx_ir_n;
    s_d.rx_ir = lb_ir ? !tx_ir_n : pin_sy[umlc_pkg::SY_IR];
    // Modem inputs; no terminal-ready bit exists, so dsr loops inactive
    if (s_q.lb_b) begin
      s_d.cts_n = !s_q.rts_b;
      s_d.dsr_n = 1'b1;
      s_d.ring_n = !s_q.out1_b;
      s_d.dcd_n = !s_q.out2_b;
    end else begin
      s_d.cts_n = pin_sy[umlc_pkg::SY_CTS];
      s_d.dsr_n = pin_sy[umlc_pkg::SY_DSR];
      s_d.ring_n = pin_sy[umlc_pkg::SY_RI];
      s_d.dcd_n = pin_sy[umlc_pkg::SY_DCD];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= RST_S;
    end else begin
      s_q <= s_d;
    end
  end

  // Bus answer: no wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = umlc_pkg::HRESP_OKAY;
  assign hrdata = s_q.rdata;

  // Effective inputs feed the interrupt logic unchanged in loopback
  assign cts_eff_n = s_q.cts_n;
  assign dsr_eff_n = s_q.dsr_n;
  assign ri_eff_n = s_q.ring_n;
  assign dcd_eff_n = s_q.dcd_n;
  assign rx_serial = s_q.rx_ser;
  assign rx_ir = s_q.rx_ir;
  assign ser_out_pin = s_q.ser_out;
  assign ir_out_n_pin = s_q.ir_out_n;
  assign rts_n = s_q.rts_n;
  assign user_line_a_n = s_q.ua_n;
  assign user_line_b_n = s_q.ub_n;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  a_plain_loop_out: assert property (
    lb_plain |=> (ser_out_pin && (rx_serial == $past(tx_serial))))
    else $error("plain loopback serial path wrong");

  a_loop_irq_src: assert property (
    s_q.lb_b |=> (cts_eff_n == !$past(s_q.rts_b)))
    else $error("looped cts not seen by core");

  a_loop_modem_in: assert property (
    s_q.lb_b
      |=> ((ri_eff_n == !$past(s_q.out1_b)) && (dcd_eff_n == !$past(s_q.out2_b))))
    else $error("loopback modem inputs not from outputs");

  a_ir_loop_out: assert property (
    lb_ir |=> (!ir_out_n_pin && (rx_ir == !$past(tx_ir_n))))
    else $error("infrared loopback path wrong");

  a_user_b_line: assert property (
    !s_q.lb_b |=> (user_line_b_n == !$past(s_q.out2_b)))
    else $error("second user line not inverse of bit");

  a_user_a_line: assert property (
    !s_q.lb_b |=> (user_line_a_n == !$past(s_q.out1_b)))
    else $error("first user line not inverse of bit");

  a_loop_user_high: assert property (
    s_q.lb_b [*2] |-> (user_line_a_n && user_line_b_n))
    else $error("user lines not held high in loopback");

  a_rts_plain: assert property (
    (!s_q.lb_b && !s_q.afce_b) |=> (rts_n == !$past(s_q.rts_b)))
    else $error("request-to-send does not follow bit");

  a_rts_gated: assert property (
    (s_q.afce_b && s_q.fifo_en_b && rx_above_trig) |=> rts_n)
    else $error("request-to-send not forced off above threshold");

  a_loop_rts_high: assert property (
    s_q.lb_b |=> rts_n)
    else $error("request-to-send not held high in loopback");

  a_afce_no_fifo: assert property (
    (!s_q.lb_b && !s_q.fifo_en_b && s_q.rts_b) |=> !rts_n)
    else $error("flow control acted without FIFOs");

  a_loop_dsr_map: assert property (
    s_q.lb_b |=> dsr_eff_n)
    else $error("looped data-set-ready not inactive");

  a_rsvd_read_zero: assert property (
    (take && !hwrite && (haddr == umlc_pkg::MLC_ADDR))
      |=> ((hrdata[0] == 1'b0) && (hrdata[31:7] == 25'h000_0000)))
    else $error("reserved bits read nonzero");

  a_ir_mode_sel: assert property (
    (s_q.lb_b && !s_q.sire_b) |=> (ir_out_n_pin == $past(tx_ir_n)))
    else $error("plain mode looped the infrared line");

  c_loop_plain: cover property (lb_plain ##1 lb_plain);
  c_loop_ir: cover property (lb_ir ##1 lb_ir);
  c_rts_gated: cover property (rts_req ##1 (rts_req && !rts_n) ##1 !rts_req);
  c_mlc_write: cover property (s_q.wr_pend && (s_q.wr_addr == umlc_pkg::MLC_ADDR));

endmodule // umlc_top
`default_nettype wire
